// >>> logic/sac_cfg.svh
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
// ****************************************
// register byte addresses
// ****************************************
`define SAC_ADDR_CTL     8'hE8
`define SAC_ADDR_RESULT  8'hEC
`define SAC_ADDR_IRQ_ST  8'hF0
`define SAC_ADDR_IRQ_CLR 8'hF4
`define SAC_ADDR_IRQ_EN  8'hF8
`define SAC_ADDR_SARDIV  8'hFC
// ****************************************
// control register fields
// ****************************************
`define SAC_CTL_EN       7
`define SAC_CTL_TM       6
`define SAC_CTL_DONE     5
`define SAC_CTL_BUSY     4
`define SAC_CTL_SRC_HI   3
`define SAC_CTL_SRC_LO   2
`define SAC_CTL_WIN      1
`define SAC_CTL_LJST     0
// ****************************************
// start source codes, reset values and interrupt bits
// ****************************************
`define SAC_SRC_SOFT     2'h0
`define SAC_SRC_TMR3     2'h1
`define SAC_SRC_EXT      2'h2
`define SAC_SRC_TMR2     2'h3
`define SAC_SARDIV_RST   5'h04
`define SAC_IRQ_N        2
`define SAC_IRQ_DONE     0
`define SAC_IRQ_WIN      1
// ****************************************
// timing in sar clocks
// ****************************************
`define SAC_TRACK_CLKS   4'h3
`define SAC_CONV_CLKS    4'hD
`endif

// >>> logic/sac_pkg.sv
package sac_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_TRACK,
      SEQ_CONV
   } sac_seq_e;
   // start source field
   typedef logic [1:0] sac_src_t;
endpackage

// >>> logic/sac_irq.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_irq (
   // clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   arst_n_i,
   // events and software access
   input  wire logic [`SAC_IRQ_N-1:0]  set_i,
   input  wire logic [`SAC_IRQ_N-1:0]  clr_i,
   input  wire logic                   en_wr_i,
   input  wire logic [`SAC_IRQ_N-1:0]  en_data_i,
   // state
   output logic      [`SAC_IRQ_N-1:0]  status_o,
   output logic      [`SAC_IRQ_N-1:0]  enable_o,
   output logic                        irq_o
);
   // ****************************************
   // sticky status, set beats clear
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < `SAC_IRQ_N; g++) begin : g_bit
         always_ff @(posedge mclk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               status_o[g] <= 1'b0;
            end else begin
               status_o[g] <= set_i[g] | (status_o[g] & ~clr_i[g]);
            end
         end
      end
   endgenerate

   // enable mask register
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         enable_o <= '0;
      end else if (en_wr_i) begin
         enable_o <= en_data_i;
      end
   end

   // level output straight from the flops, no extra latency
   assign irq_o = |(status_o & enable_o);

   set_wins_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      set_i[0] |=> status_o[0])
      else $error("event lost against a clear");
endmodule

// >>> logic/sac_sar_seq.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_sar_seq (
   // clock and reset
   input  wire logic  mclk_i,
   input  wire logic  arst_n_i,
   // control
   input  wire logic  enable_i,
   input  wire logic  lp_mode_i,
   input  wire logic  ext_gate_i,
   input  wire logic  ext_level_i,
   input  wire logic  start_i,
   input  wire logic  sar_tick_i,
   // status
   output logic       busy_o,
   output logic       track_o,
   output logic       done_o
);
   sac_pkg::sac_seq_e state_q, state_d;
   logic [3:0]        cnt_q, cnt_d;
   logic              done_d;

   // ****************************************
   // track / convert sequence
   // ****************************************
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      done_d  = 1'b0;
      case (state_q)
         sac_pkg::SEQ_IDLE: begin
            if (start_i && lp_mode_i && !ext_gate_i) begin
               state_d = sac_pkg::SEQ_TRACK;            // [RULE3] [RULE4] [RULE5]
               cnt_d   = `SAC_TRACK_CLKS - 4'h1;
            end else if (start_i) begin
               state_d = sac_pkg::SEQ_CONV;             // [RULE6] [RULE8]
               cnt_d   = `SAC_CONV_CLKS - 4'h1;
            end
         end
         sac_pkg::SEQ_TRACK: begin
            if (sar_tick_i && cnt_q == 4'h0) begin
               state_d = sac_pkg::SEQ_CONV;
               cnt_d   = `SAC_CONV_CLKS - 4'h1;
            end else if (sar_tick_i) begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         sac_pkg::SEQ_CONV: begin
            if (sar_tick_i && cnt_q == 4'h0) begin
               state_d = sac_pkg::SEQ_IDLE;
               done_d  = 1'b1;                          // [RULE7]
            end else if (sar_tick_i) begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: state_d = sac_pkg::SEQ_IDLE;
      endcase
      // shutdown aborts silently: no done flag for a lost result
      if (!enable_i) begin
         state_d = sac_pkg::SEQ_IDLE;                   // [RULE1]
         done_d  = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= sac_pkg::SEQ_IDLE;
         cnt_q   <= 4'h0;
         done_o  <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         done_o  <= done_d;
      end
   end

   // busy covers the low-power tracking period too
   assign busy_o  = state_q != sac_pkg::SEQ_IDLE;
   // normal mode tracks whenever idle; low-power only in its window
   assign track_o = enable_i & ((state_q == sac_pkg::SEQ_TRACK) |
                    ((state_q == sac_pkg::SEQ_IDLE) &
                     (!lp_mode_i | (ext_gate_i & !ext_level_i))));

   lp_track_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
      enable_i && start_i && !busy_o && lp_mode_i && !ext_gate_i
      |=> state_q == sac_pkg::SEQ_TRACK [*3])    // [RULE3]
      else $error("low-power tracking period too short");
endmodule

// >>> logic/sac_top.sv
// Behaviour
// RULE1: enable low keeps converter shut down
// RULE2: enable high accepts starts from selected source
// RULE3: low-power soft start tracks three sar clocks
// RULE4: low-power timer three start tracks three clocks
// RULE5: low-power timer two start tracks three clocks
// RULE6: normal mode source field picks trigger
// RULE7: busy during conversion; fall sets done
// RULE8: low-power external start tracks while low
// RULE9: justify select places result low or high
// RULE10: flags clear by writing zero; busy zero ignored
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_top (
   // clock and reset
   input  wire logic         mclk_i,
   input  wire logic         arst_n_i,
   // apb slave
   input  wire logic         psel_i,
   input  wire logic         penable_i,
   input  wire logic         pwrite_i,
   input  wire logic [7:0]   paddr_i,
   input  wire logic [31:0]  pwdata_i,
   output logic      [31:0]  prdata_o,
   output logic              pready_o,
   output logic              pslverr_o,
   // start sources
   input  wire logic         timer3_ovf_i,
   input  wire logic         timer2_ovf_i,
   input  wire logic         external_convert_start_i,
   // analog front end
   input  wire logic [11:0]  conv_data_i,
   input  wire logic         window_match_i,
   output logic              adc_shutdown_o,
   output logic              adc_track_o,
   output logic              adc_busy_o,
   // interrupt
   output logic              irq_o
);
   // ****************************************
   // apb decode
   // ****************************************
   wire acc      = psel_i & penable_i;
   wire setup    = psel_i & ~penable_i;
   wire hit_ctl  = paddr_i == `SAC_ADDR_CTL;
   wire hit_res  = paddr_i == `SAC_ADDR_RESULT;
   wire hit_ist  = paddr_i == `SAC_ADDR_IRQ_ST;
   wire hit_icl  = paddr_i == `SAC_ADDR_IRQ_CLR;
   wire hit_ien  = paddr_i == `SAC_ADDR_IRQ_EN;
   wire hit_div  = paddr_i == `SAC_ADDR_SARDIV;
   wire mapped   = hit_ctl | hit_res | hit_ist | hit_icl | hit_ien | hit_div;
   wire wr       = acc & pwrite_i;
   wire wr_ctl   = wr & hit_ctl;
   wire wr_div   = wr & hit_div;
   wire wr_icl   = wr & hit_icl;
   wire wr_ien   = wr & hit_ien;

   // zero wait states; read data latched in the setup cycle
   assign pready_o  = 1'b1;
   assign pslverr_o = acc & ~mapped;

   // ****************************************
   // control register
   // ****************************************
   logic                en_q;
   logic                tm_q;
   logic                ljst_q;
   sac_pkg::sac_src_t   src_q;
   logic                done_flag_q;
   logic                win_flag_q;
   logic [4:0]          div_q;
   logic [4:0]          div_cnt_q;
   logic [11:0]         result_q;
   logic                ext_q;
   logic [31:0]         prdata_q;

   // software bits
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_q   <= 1'b0;
         tm_q   <= 1'b0;
         src_q  <= `SAC_SRC_SOFT;
         ljst_q <= 1'b0;
      end else if (wr_ctl) begin
         en_q   <= pwdata_i[`SAC_CTL_EN];
         tm_q   <= pwdata_i[`SAC_CTL_TM];
         src_q  <= pwdata_i[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO];
         ljst_q <= pwdata_i[`SAC_CTL_LJST];
      end
   end

   // flags: a write of zero clears, hardware set wins the same cycle
   wire done_clr = wr_ctl & ~pwdata_i[`SAC_CTL_DONE];   // [RULE10]
   wire win_clr  = wr_ctl & ~pwdata_i[`SAC_CTL_WIN];    // [RULE10]
   wire seq_done;
   wire win_set  = window_match_i & en_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         done_flag_q <= 1'b0;
         win_flag_q  <= 1'b0;
      end else begin
         done_flag_q <= seq_done | (done_flag_q & ~done_clr);   // [RULE7]
         win_flag_q  <= win_set | (win_flag_q & ~win_clr);
      end
   end

   // ****************************************
   // sar clock tick and start selection
   // ****************************************
   // the sar clock is a tick, not a second domain, so no crossing is needed
   wire sar_tick = div_cnt_q == 5'h00;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q     <= `SAC_SARDIV_RST;
         div_cnt_q <= 5'h00;
         ext_q     <= 1'b0;
      end else begin
         div_q     <= wr_div ? pwdata_i[4:0] : div_q;
         div_cnt_q <= sar_tick ? div_q : div_cnt_q - 5'h01;
         ext_q     <= external_convert_start_i;
      end
   end

   // a busy write of zero never starts anything
   wire soft_go  = wr_ctl & pwdata_i[`SAC_CTL_BUSY];    // [RULE10]
   wire ext_rise = external_convert_start_i & ~ext_q;
   wire ext_gate = src_q == `SAC_SRC_EXT;
   logic src_go;

   // trigger mux by start source field
   always_comb begin
      case (src_q)
         `SAC_SRC_SOFT: src_go = soft_go;                // [RULE3] [RULE6]
         `SAC_SRC_TMR3: src_go = timer3_ovf_i;           // [RULE4] [RULE6]
         `SAC_SRC_EXT:  src_go = ext_rise;               // [RULE6] [RULE8]
         `SAC_SRC_TMR2: src_go = timer2_ovf_i;           // [RULE5] [RULE6]
         default:       src_go = 1'b0;
      endcase
   end

   // starts while busy are dropped, and nothing starts in shutdown
   wire seq_busy;
   wire start = en_q & src_go & ~seq_busy;               // [RULE1] [RULE2]

   sac_sar_seq u_seq (
      .mclk_i      (mclk_i),
      .arst_n_i    (arst_n_i),
      .enable_i    (en_q),
      .lp_mode_i   (tm_q),
      .ext_gate_i  (ext_gate),
      .ext_level_i (external_convert_start_i),
      .start_i     (start),
      .sar_tick_i  (sar_tick),
      .busy_o      (seq_busy),
      .track_o     (adc_track_o),
      .done_o      (seq_done)
   );

   assign adc_shutdown_o = ~en_q;                        // [RULE1]
   assign adc_busy_o     = seq_busy;

   // ****************************************
   // result capture and justification
   // ****************************************
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result_q <= 12'h000;
      end else if (seq_done) begin
         result_q <= conv_data_i;
      end
   end

   // justify at read time so a late select change still applies
   wire [31:0] res_word = ljst_q ? {16'h0000, result_q, 4'h0}
                                 : {20'h00000, result_q};     // [RULE9]

   // ****************************************
   // interrupts
   // ****************************************
   wire [`SAC_IRQ_N-1:0] irq_st;
   wire [`SAC_IRQ_N-1:0] irq_en;
   wire [`SAC_IRQ_N-1:0] irq_set = {win_set, seq_done};

   sac_irq u_irq (
      .mclk_i    (mclk_i),
      .arst_n_i  (arst_n_i),
      .set_i     (irq_set),
      .clr_i     (wr_icl ? pwdata_i[`SAC_IRQ_N-1:0] : '0),
      .en_wr_i   (wr_ien),
      .en_data_i (pwdata_i[`SAC_IRQ_N-1:0]),
      .status_o  (irq_st),
      .enable_o  (irq_en),
      .irq_o     (irq_o)                                 // [RULE7]
   );

   // ****************************************
   // read mux
   // ****************************************
   wire [7:0] ctl_rd = {en_q, tm_q, done_flag_q, seq_busy,
                        src_q, win_flag_q, ljst_q};      // [RULE7]
   wire [31:0] rd_mux =
      hit_ctl ? {24'h000000, ctl_rd} :
      hit_res ? res_word :
      hit_ist ? {30'h00000000, irq_st} :
      hit_ien ? {30'h00000000, irq_en} :
      hit_div ? {27'h0000000, div_q} : 32'h00000000;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end

   assign prdata_o = prdata_q;

   // ****************************************
   // assertions
   // ****************************************
   shutdown_idle_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE1]
      !en_q |=> !seq_busy)
      else $error("conversion running while shut down");

   start_taken_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE2]
      en_q && src_go && !seq_busy |=> seq_busy)
      else $error("enabled start was not taken");

   tmr3_track_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE4]
      en_q && tm_q && src_q == `SAC_SRC_TMR3 && timer3_ovf_i && !seq_busy
      |=> seq_busy && adc_track_o)
      else $error("timer three start did not track");

   tmr2_track_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE5]
      en_q && tm_q && src_q == `SAC_SRC_TMR2 && timer2_ovf_i && !seq_busy
      |=> seq_busy && adc_track_o)
      else $error("timer two start did not track");

   ext_normal_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE6]
      en_q && !tm_q && ext_gate && ext_rise && !seq_busy
      |=> seq_busy && !adc_track_o)
      else $error("external edge did not start conversion");

   done_irq_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE7]
      $fell(seq_busy) && seq_done && irq_en[`SAC_IRQ_DONE]
      |=> done_flag_q && irq_o)
      else $error("busy fall did not flag and interrupt");

   ext_lowtrack_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE8]
      en_q && tm_q && ext_gate && !seq_busy && !external_convert_start_i
      |-> adc_track_o)
      else $error("not tracking while external start low");

   left_just_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE9]
      setup && hit_res && ljst_q
      |=> prdata_o[3:0] == 4'h0 && prdata_o[15:4] == $past(result_q))
      else $error("left justified result misplaced");

   flag_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE10]
      done_flag_q && !done_clr |=> done_flag_q)
      else $error("done flag dropped without a clear");

   win_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE10]
      win_flag_q && !win_clr |=> win_flag_q)
      else $error("window flag dropped without a clear");

   busy_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE10]
      en_q && wr_ctl && !pwdata_i[`SAC_CTL_BUSY] && src_q == `SAC_SRC_SOFT && !seq_busy
      |=> !seq_busy)
      else $error("busy write of zero started a conversion");

   // a write that also disables is left out, as the sequencer then aborts
   lp_soft_track_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE3]
      en_q && tm_q && src_q == `SAC_SRC_SOFT && soft_go && pwdata_i[`SAC_CTL_EN] && !seq_busy
      |=> seq_busy && adc_track_o)
      else $error("soft start did not begin tracking");

   no_trigger_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE6]
      en_q && !src_go && !seq_busy |=> !seq_busy)
      else $error("conversion began with no trigger");

   shutdown_track_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE1]
      !en_q |-> !adc_track_o && adc_shutdown_o)
      else $error("front end active while shut down");

   right_just_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE9]
      setup && hit_res && !ljst_q
      |=> prdata_o[31:12] == 20'h00000 && prdata_o[11:0] == $past(result_q))
      else $error("right justified result misplaced");

   // main scenarios that the bench is expected to reach

   soft_conv_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      soft_go && start ##[1:200] seq_done);
   lp_timer_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      tm_q && timer2_ovf_i && start ##[1:200] seq_done);
   window_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      win_set && irq_en[`SAC_IRQ_WIN] ##1 irq_o);
   ext_lp_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      tm_q && ext_gate && start ##[1:200] seq_done);
   abort_c: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
      seq_busy && !en_q ##1 !seq_busy);
endmodule

// >>> tb/sac_tb.sv
`timescale 1ns/1ps
`include "sac_cfg.svh"
module testbench;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic        mclk_i = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel   = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        t3     = 1'b0;
   logic        t2     = 1'b0;
   logic        ext    = 1'b0;
   logic [11:0] cdata  = 12'h000;
   logic        wmatch = 1'b0;
   wire  logic [31:0] prdata;
   wire  logic        pready;
   wire  logic        pslverr;
   wire  logic        shut;
   wire  logic        track;
   wire  logic        busy;
   wire  logic        irq;
   logic [31:0] rdv;
   logic        errv;
   int          n_mismatch = 0;
   int          tests_run  = 0;
   int          nb;
   int          nt;
   int          seed_val;
   logic        lj;

   // clock at 10 MHz
   always #50 mclk_i = ~mclk_i;

   sac_top u_dut (
      .mclk_i(mclk_i), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .timer3_ovf_i(t3), .timer2_ovf_i(t2),
      .external_convert_start_i(ext), .conv_data_i(cdata), .window_match_i(wmatch),
      .adc_shutdown_o(shut), .adc_track_o(track), .adc_busy_o(busy), .irq_o(irq));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rng(input string what, input int n, input int lo, input int hi);
      chk(what, 32'h1, {31'h0, (n >= lo && n <= hi)});
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      // only the watchdog ends a wait for the slave
      do begin
         @(posedge mclk_i);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // flag bits written as 1 so that a plain control write leaves them alone
   function automatic logic [31:0] ctl(input logic en, tm, bs, input logic [1:0] s,
                                       input logic j);
      return {24'h0, en, tm, 1'b1, bs, s, 1'b1, j};
   endfunction

   function automatic logic [31:0] just(input logic [11:0] r, input logic j);
      return j ? {16'h0, r, 4'h0} : {20'h0, r};
   endfunction

   // fire trigger k while source cur is programmed
   task automatic fire(input logic [1:0] k, input logic [1:0] cur, input logic tm);
      if (k == `SAC_SRC_SOFT) begin
         wr(`SAC_ADDR_CTL, ctl(1'b1, tm, 1'b1, cur, lj));
      end else if (k == `SAC_SRC_EXT) begin
         @(posedge mclk_i);
         ext <= 1'b1;
      end else begin
         @(posedge mclk_i);
         t3 <= (k == `SAC_SRC_TMR3);
         t2 <= (k == `SAC_SRC_TMR2);
         @(posedge mclk_i);
         t3 <= 1'b0;
         t2 <= 1'b0;
      end
   endtask

   // counts busy cycles and tracking cycles within them; zero if no start
   task automatic conv();
      int w;
      nb = 0;
      nt = 0;
      w = 0;
      while (busy !== 1'b1 && w < 8) begin
         @(posedge mclk_i);
         w++;
      end
      while (busy === 1'b1 && nb < 60) begin
         if (track === 1'b1) nt++;
         nb++;
         @(posedge mclk_i);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      seed_val = $urandom(58);
      lj = 1'b0;
      repeat (6) @(posedge mclk_i);
      arst_n <= 1'b1;
      rd(`SAC_ADDR_CTL);
      chk("ctl reset", 32'h0, rdv);
      chk("shutdown", 32'h1, {31'h0, shut});
      rd(`SAC_ADDR_SARDIV);
      chk("divider reset", 32'h4, rdv);
      rd(8'h10);
      chk("unmapped err", 32'h1, {31'h0, errv});
      chk("unmapped data", 32'h0, rdv);
      // soft start while disabled must be ignored
      wr(`SAC_ADDR_CTL, ctl(1'b0, 1'b0, 1'b1, `SAC_SRC_SOFT, 1'b0));
      conv();
      chk("disabled soft", 32'h0, nb);
      wr(`SAC_ADDR_SARDIV, 32'h0);
      wr(`SAC_ADDR_IRQ_EN, 32'h3);
      // every source in both tracking modes, random data and justification
      for (int tm = 0; tm < 2; tm++) begin
         for (int s = 0; s < 4; s++) begin
            cdata <= 12'($urandom);
            lj = 1'($urandom);
            wr(`SAC_ADDR_CTL, ctl(1'b1, tm[0], 1'b0, s[1:0], lj));
            // let the write edge settle before looking at the output
            @(negedge mclk_i);
            chk("shutdown off", 32'h0, {31'h0, shut});
            fire(s[1:0] ^ 2'h1, s[1:0], tm[0]);
            conv();
            chk("wrong trigger", 32'h0, nb);
            if (tm == 1 && s == 2) begin
               @(posedge mclk_i);
               ext <= 1'b0;
               repeat (2) @(posedge mclk_i);
               chk("ext low tracks", 32'h1, {31'h0, track});
            end
            fire(s[1:0], s[1:0], tm[0]);
            conv();
            if (tm == 1 && s != 2) begin
               rng("lp busy len", nb, 15, 17);
               rng("lp track len", nt, 2, 3);
            end else begin
               rng("busy len", nb, 13, 14);
               chk("no track", 32'h0, nt);
            end
            rd(`SAC_ADDR_CTL);
            chk("done set busy low", 32'h20, rdv & 32'h30);
            chk("irq done", 32'h1, {31'h0, irq});
            rd(`SAC_ADDR_RESULT);
            chk("result", just(cdata, lj), rdv);
            wr(`SAC_ADDR_CTL, ctl(1'b1, tm[0], 1'b0, s[1:0], lj));
            conv();
            chk("busy zero write", 32'h0, nb);
            rd(`SAC_ADDR_CTL);
            chk("done sticky", 32'h20, rdv & 32'h20);
            wr(`SAC_ADDR_CTL, ctl(1'b1, tm[0], 1'b0, s[1:0], lj) & 32'hFFFF_FFDD);
            rd(`SAC_ADDR_CTL);
            chk("done cleared", 32'h0, rdv & 32'h20);
            wr(`SAC_ADDR_IRQ_CLR, 32'h1);
            @(negedge mclk_i);
            chk("irq cleared", 32'h0, {31'h0, irq});
            @(posedge mclk_i);
            ext <= 1'b0;
         end
      end
      // window flag, masking and clearing of its interrupt
      @(posedge mclk_i);
      wmatch <= 1'b1;
      @(posedge mclk_i);
      wmatch <= 1'b0;
      rd(`SAC_ADDR_CTL);
      chk("window flag", 32'h2, rdv & 32'h2);
      chk("irq window", 32'h1, {31'h0, irq});
      wr(`SAC_ADDR_IRQ_EN, 32'h1);
      @(negedge mclk_i);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(`SAC_ADDR_IRQ_ST);
      chk("status window", 32'h2, rdv);
      wr(`SAC_ADDR_IRQ_CLR, 32'h2);
      rd(`SAC_ADDR_IRQ_ST);
      chk("status clear", 32'h0, rdv);
      wr(`SAC_ADDR_CTL, ctl(1'b1, 1'b0, 1'b0, `SAC_SRC_SOFT, 1'b0) & 32'hFFFF_FFFD);
      rd(`SAC_ADDR_CTL);
      chk("window cleared", 32'h0, rdv & 32'h2);
      // disabling mid-conversion aborts with no done flag
      wr(`SAC_ADDR_CTL, ctl(1'b1, 1'b1, 1'b0, `SAC_SRC_SOFT, 1'b0));
      fire(`SAC_SRC_SOFT, `SAC_SRC_SOFT, 1'b1);
      repeat (3) @(posedge mclk_i);
      wr(`SAC_ADDR_CTL, ctl(1'b0, 1'b1, 1'b0, `SAC_SRC_SOFT, 1'b0));
      repeat (25) @(posedge mclk_i);
      chk("abort busy", 32'h0, {31'h0, busy});
      rd(`SAC_ADDR_CTL);
      chk("abort no done", 32'h0, rdv & 32'h20);
      give_verdict();
   end

   // hang guard, well beyond the several hundred cycles the tests need
   initial begin
      #5000000;
      n_mismatch++;
      give_verdict();
   end
endmodule
